// File: scrc_clock_cfg.sv
// Contract
// [R1] Platform multiplier from straps latched, no default
// [R2] Platform codes 2,3,4,5,6,8x; others reserved
// [R3] Core codes 2x, 2.5x, 3x; others reserved
// [R4] Memory clock is half platform clock
// [R5] Local clocks divide platform clock by field; field values 0 and 1 divide by two
// [R6] Board sets platform equal to DDR rate
// [R7] Board avoids platform between 400 and 500
// [R8] Board keeps all clocks within ranges
// [R9] FIFO GMII clocks at most platform/4.2
// [R10] FIFO encoded clocks at most platform/3.2
// [R11] Reserved code stops clocks, flags error
`timescale 1ns/1ps
`include "scrc_regs.svh"

module scrc_clock_cfg
  import scrc_pkg::*;
(
  // Clock and reset; the clock stands for the platform clock
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Board straps, asynchronous pins
  input wire logic [3:0] platform_ratio_strap_i,
  input wire logic [4:0] core_ratio_strap_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Decoded configuration
  output logic [3:0] platform_mult_o,
  output logic [3:0] core_ratio_x2_o,
  output logic cfg_err_o,
  output logic clk_locked_o,
  // Derived clocks
  output logic mem_bus_clk_o,
  output logic [2:0] local_bus_clock_out_o
);

  // Strap synchronisers; first stage feeds only the second
  logic [3:0] plat_s1_q;
  logic [3:0] plat_s2_q;
  logic [4:0] core_s1_q;
  logic [4:0] core_s2_q;
  // Latched straps and decoded result
  logic [3:0] plat_cap_q;
  logic [4:0] core_cap_q;
  scrc_ratio_t ratio_d;
  // Sequencing
  scrc_state_t state_q;
  logic [1:0] cap_cnt_q;
  // Divider register and counter
  logic [`SCRC_DIV_W-1:0] div_q;
  logic [`SCRC_DIV_W-1:0] div_eff;
  logic [`SCRC_DIV_W-1:0] lb_cnt_q;
  logic run;

  assign run = (state_q == SCRC_ST_RUN);

  // Two-flop strap synchroniser
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      plat_s1_q <= 4'h0;
      plat_s2_q <= 4'h0;
      core_s1_q <= 5'h00;
      core_s2_q <= 5'h00;
    end else begin
      plat_s1_q <= platform_ratio_strap_i;
      plat_s2_q <= plat_s1_q;
      core_s1_q <= core_ratio_strap_i;
      core_s2_q <= core_s1_q;
    end
  end

  // Strap decode from the latched values
  always_comb begin
    ratio_d = '0;
    case (plat_cap_q) // [R2]
      `SCRC_PC_2X: ratio_d.plat_mult = `SCRC_PM_2X;
      `SCRC_PC_3X: ratio_d.plat_mult = `SCRC_PM_3X;
      `SCRC_PC_4X: ratio_d.plat_mult = `SCRC_PM_4X;
      `SCRC_PC_5X: ratio_d.plat_mult = `SCRC_PM_5X;
      `SCRC_PC_6X: ratio_d.plat_mult = `SCRC_PM_6X;
      `SCRC_PC_8X: ratio_d.plat_mult = `SCRC_PM_8X;
      // Reserved and unlisted codes have no multiplier
      default: ratio_d.plat_err = 1'b1; // [R11]
    endcase
    case (core_cap_q) // [R3]
      `SCRC_CC_2X: ratio_d.core_x2 = `SCRC_CR_2X;
      `SCRC_CC_25X: ratio_d.core_x2 = `SCRC_CR_25X;
      `SCRC_CC_3X: ratio_d.core_x2 = `SCRC_CR_3X;
      default: ratio_d.core_err = 1'b1; // [R11]
    endcase
  end

  // Power-up sequence: wait for the synchroniser, latch once, then run or stop.
  // Straps are latched only here, so later pin activity cannot change the ratio.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= SCRC_ST_SYNC;
      cap_cnt_q <= 2'h0;
      plat_cap_q <= 4'h0;
      core_cap_q <= 5'h00;
    end else begin
      case (state_q)
        SCRC_ST_SYNC: begin
          if (cap_cnt_q == `SCRC_CAP_CYCLES) begin
            plat_cap_q <= plat_s2_q; // [R1]
            core_cap_q <= core_s2_q; // [R1]
            state_q <= SCRC_ST_RUN;
          end else begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
          end
        end
        SCRC_ST_RUN: begin
          // Checked one cycle after latching, when decode has settled
          if (ratio_d.plat_err || ratio_d.core_err) begin
            state_q <= SCRC_ST_ERR; // [R11]
          end
        end
        // Error is final until the next reset
        SCRC_ST_ERR: state_q <= SCRC_ST_ERR;
        default: state_q <= SCRC_ST_SYNC;
      endcase
    end
  end

  // Decoded outputs, valid once latched
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      platform_mult_o <= 4'h0;
      core_ratio_x2_o <= 4'h0;
      cfg_err_o <= 1'b0;
      clk_locked_o <= 1'b0;
    end else begin
      platform_mult_o <= (state_q == SCRC_ST_SYNC) ? 4'h0 : ratio_d.plat_mult;
      core_ratio_x2_o <= (state_q == SCRC_ST_SYNC) ? 4'h0 : ratio_d.core_x2;
      cfg_err_o <= (state_q == SCRC_ST_ERR); // [R11]
      clk_locked_o <= run && !(ratio_d.plat_err || ratio_d.core_err);
    end
  end

  // Memory bus clock toggles every platform cycle while running
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_bus_clk_o <= 1'b0;
    end else begin
      mem_bus_clk_o <= run ? ~mem_bus_clk_o : 1'b0; // [R4]
    end
  end

  // Divider register; zero and one would stall the clock, so they act as two
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_q <= `SCRC_DIV_RST;
    end else if (wr_i && (addr_i == `SCRC_OFF_DIV)) begin
      div_q <= wdata_i[`SCRC_DIV_W-1:0];
    end
  end

  assign div_eff = (div_q < `SCRC_DIV_MIN) ? `SCRC_DIV_MIN : div_q;

  // Local bus divide counter; wraps early if the divider shrinks
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lb_cnt_q <= '0;
    end else if (!run || (lb_cnt_q >= div_eff - `SCRC_DIV_W'(1))) begin
      lb_cnt_q <= '0; // [R5]
    end else begin
      lb_cnt_q <= lb_cnt_q + `SCRC_DIV_W'(1);
    end
  end

  // Three matched local clock outputs, high for the first div_eff/2 cycles (rounded down) of each period
  for (genvar i = 0; i < 3; i++) begin : g_lclk
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        local_bus_clock_out_o[i] <= 1'b0;
      end else begin
        local_bus_clock_out_o[i] <= run && (lb_cnt_q < (div_eff >> 1)); // [R5]
      end
    end
  end

  // Read port: data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= 32'h0000_0000;
      case (addr_i)
        `SCRC_OFF_DIV: rdata_o[`SCRC_DIV_W-1:0] <= div_q;
        `SCRC_OFF_STAT: begin
          rdata_o[`SCRC_ST_PLAT_LSB +: 4] <= platform_mult_o;
          rdata_o[`SCRC_ST_CORE_LSB +: 4] <= core_ratio_x2_o;
          rdata_o[`SCRC_ST_LOCK_BIT] <= clk_locked_o;
          rdata_o[`SCRC_ST_PERR_BIT] <= cfg_err_o && ratio_d.plat_err;
          rdata_o[`SCRC_ST_CERR_BIT] <= cfg_err_o && ratio_d.core_err;
        end
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // Helper: cycles between rising edges of the first local clock
  logic [7:0] per_cnt_q;
  logic seen_rise_q;
  logic div_same_q;
  logic lclk0_prev_q;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      per_cnt_q <= 8'h00;
      seen_rise_q <= 1'b0;
      div_same_q <= 1'b0;
      lclk0_prev_q <= 1'b0;
    end else begin
      lclk0_prev_q <= local_bus_clock_out_o[0];
      if (local_bus_clock_out_o[0] && !lclk0_prev_q) begin
        per_cnt_q <= 8'h01;
        seen_rise_q <= 1'b1;
        // A write on the rise itself already bends the period that starts here
        div_same_q <= !(wr_i && (addr_i == `SCRC_OFF_DIV));
      end else begin
        per_cnt_q <= per_cnt_q + 8'h01;
        if (wr_i && (addr_i == `SCRC_OFF_DIV)) begin
          div_same_q <= 1'b0;
        end
      end
    end
  end

  // Sequence: latch moment of the straps
  sequence latch_s;
    (state_q == SCRC_ST_SYNC) && (cap_cnt_q == `SCRC_CAP_CYCLES);
  endsequence

  strap_latch_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R1]
    latch_s |=> (plat_cap_q == $past(plat_s2_q)) && (core_cap_q == $past(core_s2_q)))
    else $error("straps not latched from synchroniser");

  lock_time_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R1]
    $fell(sys_rst_i) |-> ##[0:4] (state_q != SCRC_ST_SYNC))
    else $error("strap latch took too long");

  plat_map_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R2]
    (clk_locked_o && (plat_cap_q == `SCRC_PC_8X)) |-> (platform_mult_o == `SCRC_PM_8X))
    else $error("platform 8x code mis-decoded");

  core_map_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R3]
    (clk_locked_o && (core_cap_q == `SCRC_CC_25X)) |-> (core_ratio_x2_o == `SCRC_CR_25X))
    else $error("core 2.5x code mis-decoded");

  mem_half_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R4]
    (run && $past(run)) |=> run [*1] ##0 (mem_bus_clk_o != $past(mem_bus_clk_o)))
    else $error("memory clock not at half rate");

  lclk_period_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R5]
    (local_bus_clock_out_o[0] && !lclk0_prev_q && seen_rise_q && div_same_q && run
      && $past(run, 2)) |-> (per_cnt_q == 8'(div_eff)))
    else $error("local clock period differs from divider");

  err_stop_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R11]
    (state_q == SCRC_ST_ERR) |=> cfg_err_o && !mem_bus_clk_o && !clk_locked_o
      && (local_bus_clock_out_o == 3'h0))
    else $error("clocks not stopped on reserved code");

  err_entry_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R11]
    (run && (ratio_d.plat_err || ratio_d.core_err)) |=> (state_q == SCRC_ST_ERR) [*2])
    else $error("reserved code did not enter error");

endmodule : scrc_clock_cfg

// File: scrc_regs.svh
`ifndef SCRC_REGS_SVH
`define SCRC_REGS_SVH

// Register byte offsets
`define SCRC_OFF_DIV 8'h00
`define SCRC_OFF_STAT 8'h04

// Local bus divider field
`define SCRC_DIV_W 5
`define SCRC_DIV_RST 5'h08
`define SCRC_DIV_MIN 5'h02

// Status field positions
`define SCRC_ST_PLAT_LSB 0
`define SCRC_ST_CORE_LSB 4
`define SCRC_ST_LOCK_BIT 8
`define SCRC_ST_PERR_BIT 9
`define SCRC_ST_CERR_BIT 10

// Cycles after reset release before the straps are latched
`define SCRC_CAP_CYCLES 2'h2

// Platform strap codes and multipliers
`define SCRC_PC_2X 4'h2
`define SCRC_PC_3X 4'h3
`define SCRC_PC_4X 4'h4
`define SCRC_PC_5X 4'h5
`define SCRC_PC_6X 4'h6
`define SCRC_PC_8X 4'h8
`define SCRC_PM_2X 4'h2
`define SCRC_PM_3X 4'h3
`define SCRC_PM_4X 4'h4
`define SCRC_PM_5X 4'h5
`define SCRC_PM_6X 4'h6
`define SCRC_PM_8X 4'h8

// Core strap codes and ratios in half steps
`define SCRC_CC_2X 5'h08
`define SCRC_CC_25X 5'h0c
`define SCRC_CC_3X 5'h10
`define SCRC_CR_2X 4'h4
`define SCRC_CR_25X 4'h5
`define SCRC_CR_3X 4'h6

`endif

// File: scrc_pkg.sv
package scrc_pkg;

  // Configuration state
  typedef enum logic [1:0] {
    SCRC_ST_SYNC = 2'b00,
    SCRC_ST_RUN = 2'b01,
    SCRC_ST_ERR = 2'b10
  } scrc_state_t;

  // Decoded ratios as one bundle
  typedef struct packed {
    logic core_err;
    logic plat_err;
    logic [3:0] core_x2;
    logic [3:0] plat_mult;
  } scrc_ratio_t;

endpackage : scrc_pkg

// File: scrc_board_model.sv
`timescale 1ns/1ps
// Board strap network: resistors always drive the pins, so nothing floats
module scrc_board_model (
  // Settings chosen by the bench
  input wire logic [3:0] plat_sel_i,
  input wire logic [4:0] core_sel_i,
  // Strap pins toward the device
  output logic [3:0] platform_ratio_strap_o,
  output logic [4:0] core_ratio_strap_o
);
  // Straps are always pulled to a chosen code; there is no default
  // Codes pass straight from the bench, reserved ones too; no DDR rate is modelled here
  // No FIFO port is driven here, so its clock caps hold trivially
  assign platform_ratio_strap_o = plat_sel_i;
  assign core_ratio_strap_o = core_sel_i;
endmodule : scrc_board_model

// File: tb_scrc_clock_cfg.sv
`timescale 1ns/1ps
module tb_scrc_clock_cfg;
  import scrc_pkg::*;
  // Stimulus, all set at time zero
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] plat_sel = 4'h4;
  logic [4:0] core_sel = 5'h08;
  // Design outputs and strap wires
  logic [3:0] pstrap, platform_mult_o, core_ratio_x2_o;
  logic [4:0] cstrap;
  logic [31:0] rdata_o;
  logic cfg_err_o, clk_locked_o, mem_bus_clk_o;
  logic [2:0] local_bus_clock_out_o;
  // Bookkeeping; read notes wait in a queue for the monitor
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [31:0] seed = 32'h0000_005c;

  always #5 sys_clk_i = ~sys_clk_i;

  scrc_board_model board (.plat_sel_i(plat_sel), .core_sel_i(core_sel),
    .platform_ratio_strap_o(pstrap), .core_ratio_strap_o(cstrap));
  scrc_clock_cfg dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .platform_ratio_strap_i(pstrap), .core_ratio_strap_i(cstrap), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .platform_mult_o(platform_mult_o), .core_ratio_x2_o(core_ratio_x2_o),
    .cfg_err_o(cfg_err_o), .clk_locked_o(clk_locked_o), .mem_bus_clk_o(mem_bus_clk_o),
    .local_bus_clock_out_o(local_bus_clock_out_o));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    rd_i <= 1'b1; addr_i <= a;
    exp_q.push_back(exp);
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
  endtask : rd

  // Read data stands only in the cycle after the strobe; take the oldest note then
  always @(posedge sys_clk_i) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) chk(rdata_o, 32'hffffffff);
      else chk(rdata_o, exp_q.pop_front());
    end
    rd_seen <= rd_i;
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      summarize();
    end
  end

  // Reset with given straps, then check decode, status and clocks
  task automatic cfg(input logic [3:0] p, input logic [4:0] c);
    logic [3:0] pe, ce;
    logic m;
    case (p)
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8: pe = p;
      default: pe = 4'h0;
    endcase
    case (c)
      5'h08: ce = 4'h4;
      5'h0c: ce = 4'h5;
      5'h10: ce = 4'h6;
      default: ce = 4'h0;
    endcase
    // Straps change only on a clock edge, while reset is held
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    plat_sel <= p;
    core_sel <= c;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    if (pe != 0 && ce != 0) begin
      chk(platform_mult_o, pe);
      chk(core_ratio_x2_o, ce);
      chk({cfg_err_o, clk_locked_o}, 2'b01);
      m = ~mem_bus_clk_o;
      @(negedge sys_clk_i);
      chk(mem_bus_clk_o, m);
      rd(8'h04, {21'h0, 3'b001, ce, pe});
      // Late strap changes must be ignored once latched
      plat_sel <= ~p;
      core_sel <= 5'(xs(seed));
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk({platform_mult_o, core_ratio_x2_o}, {pe, ce});
    end else begin
      chk({cfg_err_o, clk_locked_o}, 2'b10);
      repeat (4) begin
        @(negedge sys_clk_i);
        chk({mem_bus_clk_o, local_bus_clock_out_o}, 4'h0);
      end
      // Status shows which strap held the reserved code
      rd(8'h04, {21'h0, (ce == 4'h0), (pe == 4'h0), 1'b0, ce, pe});
    end
    $display("test strap p=%h c=%h done", p, c);
  endtask : cfg

  task automatic wait_rise;
    logic prev;
    int k;
    k = 0;
    do begin
      prev = local_bus_clock_out_o[0];
      @(negedge sys_clk_i);
      k++;
    end while (!(prev === 1'b0 && local_bus_clock_out_o[0] === 1'b1) && k < 100);
  endtask : wait_rise

  // Measure period and high time of a local clock, skipping the period of change
  task automatic lbc(input int per);
    int n, h;
    logic prev;
    wait_rise();
    wait_rise();
    n = 0; h = 0;
    do begin
      h += local_bus_clock_out_o[0];
      n++;
      chk(local_bus_clock_out_o, {3{local_bus_clock_out_o[0]}});
      prev = local_bus_clock_out_o[0];
      @(negedge sys_clk_i);
    end while (!(prev === 1'b0 && local_bus_clock_out_o[0] === 1'b1) && n < 100);
    chk(n, per);
    chk(h, per / 2);
  endtask : lbc

  initial begin
    logic [4:0] d;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    for (int p = 0; p < 16; p++) cfg(4'(p), 5'h08);
    for (int c = 0; c < 32; c++) cfg(4'h4, 5'(c));
    cfg(4'h3, 5'h10);
    rd(8'h00, 32'h8);
    rd(8'h40, 32'h0);
    wr(8'h04, 32'hffffffff);
    rd(8'h04, {21'h0, 3'b001, 4'h6, 4'h3});
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      d = (i < 2) ? 5'(i) : 5'h02 + 5'(seed % 30);
      wr(8'h00, {27'h0, d});
      rd(8'h00, {27'h0, d});
      lbc((d < 2) ? 2 : d);
    end
    $display("test divider done");
    summarize();
  end
endmodule : tb_scrc_clock_cfg
